// ### bench/ingress_event_props.sv
// assertion checker for the ingress event selector bus side and counting flag
`timescale 1ns/1ps
`default_nettype none
module ingress_event_props #(
  parameter int CNT_W = 48,
  parameter int OCC_W = 6
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        counting
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  logic mapped;
  logic en_q;
  logic next_en_q;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  assign mapped = paddr[1:0] == 2'b00 && paddr[11:4] == 8'h00;
  always_comb begin
    next_en_q = ctrl_wr ? pwdata[16] : en_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 1'b0;
    else en_q <= next_en_q;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence occ_arm_s;
    ctrl_wr && !en_q && pwdata[16] && pwdata[7:0] == 8'h11;
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no answer after setup");
  ready_single_a: assert property (setup_s ##1 access_s |=> !pready)
    else $error("pready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  unmapped_error_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  disable_stops_a: assert property (ctrl_wr && !pwdata[16] |=> ##1 !counting)
    else $error("counting after disable");
  occ_start_a: assert property (occ_arm_s |=> ##1 counting)
    else $error("occupancy not started");
  counting_hold_a: assert property (!ctrl_wr && !$past(ctrl_wr) |=> $stable(counting))
    else $error("counting changed without write");
  status_match_a: assert property (pready && !pwrite && paddr == 12'h00C |-> prdata[1] == $past(counting))
    else $error("status disagrees with counting");
  clear_reads0_a: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[17])
    else $error("clear bit reads one");
endmodule // ingress_event_props
bind ingress_reject_retry_event_select ingress_event_props #(.CNT_W(CNT_W), .OCC_W(OCC_W)) props_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .counting(counting));
`default_nettype wire

// ### bench/ingress_queue_model.sv
// far-side model: ingress queues raising reject causes and occupancy
`timescale 1ns/1ps
`default_nettype none
module ingress_queue_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [15:0] rnd,
  output logic      [63:0] first_cause,
  output logic      [63:0] second_cause,
  output logic      [5:0]  occ_a,
  output logic      [5:0]  occ_b,
  output logic      [5:0]  occ_c
);
  // ****************************************************************
  // per-cycle cause levels, quiet outside a burst
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_cause <= 64'h0;
      second_cause <= 64'h0;
      occ_a <= 6'h00;
      occ_b <= 6'h00;
      occ_c <= 6'h00;
    end else if (!run) begin
      first_cause <= 64'h0;
      second_cause <= 64'h0;
      occ_a <= 6'h00;
      occ_b <= 6'h00;
      occ_c <= 6'h00;
    end else begin
      first_cause <= {first_cause[47:0], rnd};
      second_cause <= {second_cause[51:0], rnd[11:0]};
      occ_a <= rnd[5:0];
      occ_b <= rnd[11:6];
      occ_c <= rnd[15:10];
    end
  end
endmodule // ingress_queue_model
`default_nettype wire

// ### bench/ingress_reject_retry_event_select_tb_top.sv
// testbench for the ingress event selector
`timescale 1ns/1ps
`default_nettype none
module ingress_reject_retry_event_select_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        counting;
  logic [63:0] fs;
  logic [63:0] ss;
  logic [5:0]  occ_a;
  logic [5:0]  occ_b;
  logic [5:0]  occ_c;
  logic        run = 1'b0;
  logic [15:0] rnd = 16'h002A;
  logic [47:0] exp_cnt = 48'h0;
  logic [47:0] base;
  logic [31:0] rd;
  logic [31:0] lo;
  logic        err;
  logic [7:0]  m;
  logic [7:0]  cur_mask = 8'h00;
  int          sel = 17;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [7:0]  codes [18] = '{8'h18, 8'h19, 8'h22, 8'h23, 8'h24, 8'h25, 8'h2C, 8'h2D, 8'h20,
                              8'h21, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2E, 8'h2F, 8'h11, 8'h00};
  logic [7:0]  occ_m [4] = '{8'h04, 8'h40, 8'h80, 8'hFF};

  ingress_reject_retry_event_select dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_stage_cause(fs),
    .second_stage_cause(ss), .core_snoop_queue_entries(occ_a), .remote_request_queue_entries(occ_b),
    .writeback_queue_entries(occ_c), .counting(counting));
  ingress_queue_model far (
    .pclk(pclk), .presetn(presetn), .run(run), .rnd(rnd), .first_cause(fs), .second_cause(ss),
    .occ_a(occ_a), .occ_b(occ_b), .occ_c(occ_c));

  // ****************************************************************
  // expectation and stimulus helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] inc_of(input int i, input logic [7:0] k);
    logic [7:0] fb;
    logic [7:0] sb;
    if (i == 16) return (k[2] ? 8'(occ_a) : 8'h00) + (k[6] ? 8'(occ_b) : 8'h00) + (k[7] ? 8'(occ_c) : 8'h00);
    if (i == 17) return 8'h00;
    fb = fs[(i / 2) * 8 +: 8];
    sb = {ss[(i / 2) * 8 + 1 +: 7], |fb};
    return (i % 2) ? 8'(|(sb & k)) : 8'(|(fb & k));
  endfunction
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    rnd <= lfsr(rnd);
    exp_cnt <= exp_cnt + 48'(inc_of(sel, cur_mask));
    if (cycles > 8000) begin
      bad_count++;
      results();
    end
  end
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, want, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic one_run(input int i, input logic [7:0] k);
    apb(1'b1, 12'h000, 32'h0002_0000);
    apb(1'b1, 12'h000, {14'h0, 1'b0, 1'b1, k, codes[i]});
    sel = i;
    cur_mask = k;
    // a second enable must not replace the running selection
    apb(1'b1, 12'h000, {14'h0, 1'b0, 1'b1, ~k, 8'h11});
    @(posedge pclk);
    check("counting", counting, i != 17);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl_hold", rd, {15'h0, 1'b1, k, codes[i]});
    apb(1'b0, 12'h00C, 32'h0);
    check("status", rd, (i != 17) ? 32'h3 : 32'h0);
    base = exp_cnt;
    run <= 1'b1;
    repeat (16) @(posedge pclk);
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    lo = rd;
    apb(1'b0, 12'h008, 32'h0);
    check("count", {rd[15:0], lo}, exp_cnt - base);
    apb(1'b1, 12'h000, 32'h0002_0000);
    apb(1'b0, 12'h004, 32'h0);
    check("count_cleared", {err, rd}, 33'h0);
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, 12'(a * 4), 32'h0);
      check("reset_value", {err, rd}, 33'h0);
    end
    apb(1'b1, 12'h010, 32'h0001_FFFF);
    check("unmapped_wr", err, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped_rd", {err, rd}, {1'b1, 32'h0});
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl_untouched", rd, 32'h0);
    for (int i = 0; i < 18; i++) begin
      for (int p = 0; p < ((i == 16) ? 4 : 2); p++) begin
        m = (i == 16) ? occ_m[p] : (p ? rnd[7:0] : 8'h01 << ((i / 2) % 8));
        one_run(i, m);
      end
    end
    results();
  end
endmodule // ingress_reject_retry_event_select_tb_top
`default_nettype wire

// ### verilog/event_accumulator.sv
// event count accumulator with clear and add
`timescale 1ns/1ps
`default_nettype none

module event_accumulator #(
  parameter int CNT_W = 48,
  parameter int INC_W = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic [INC_W-1:0] inc,
  output logic      [CNT_W-1:0] value
);

  logic [CNT_W-1:0] next_value;

  if (INC_W > CNT_W) begin : g_inc_w_check
    $error("increment wider than counter");
  end

  always_comb begin
    if (clear) begin
      next_value = '0;
    end else begin
      next_value = value + CNT_W'(inc);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= '0;
    end else begin
      value <= next_value;
    end
  end

endmodule // event_accumulator

`default_nettype wire

// ### verilog/ingress_event_pkg.sv
// constants, field layout and event decoding for the ingress reject/retry event selector
package ingress_event_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] COUNT_LO_OFFSET = 12'h004;
  localparam logic [11:0] COUNT_HI_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET   = 12'h00C;

  // ctrl fields
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_MASK_LSB = 8;
  localparam int CTRL_EN_BIT   = 16;
  localparam int CTRL_CLR_BIT  = 17;
  localparam logic [7:0] CTRL_CODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK_RESET = 8'h00;

  // status fields
  localparam int STATUS_VALID_BIT = 0;
  localparam int STATUS_ACTIVE_BIT = 1;

  // ****************************************************************
  // first-stage cause bit positions
  // ****************************************************************
  localparam int ADDR_RING_REQ_CREDIT_MISS      = 0;
  localparam int ADDR_RING_RSP_CREDIT_MISS      = 1;
  localparam int DATA_RING_RSP_CREDIT_MISS      = 2;
  localparam int DATA_RING_WRITEBACK_CREDIT_MISS = 3;
  localparam int DATA_RING_BYPASS_CREDIT_MISS   = 4;
  localparam int DATA_RING_STANDARD_CREDIT_MISS = 5;
  localparam int ACK_RING_INJECT_FAIL           = 6;
  localparam int INVAL_RING_INJECT_FAIL         = 7;

  // ****************************************************************
  // second-stage cause bit positions
  // ****************************************************************
  localparam int FIRST_STAGE_ANY      = 0;
  localparam int NO_FILTER_VICTIM     = 3;
  localparam int WAY_CONFLICT         = 5;
  localparam int ADDRESS_MATCH_REJECT = 7;

  // ****************************************************************
  // occupancy mask values
  // ****************************************************************
  localparam logic [7:0] OCC_CORE_SNOOP_MASK     = 8'h04;
  localparam logic [7:0] OCC_REMOTE_REQUEST_MASK = 8'h40;
  localparam logic [7:0] OCC_WRITEBACK_MASK      = 8'h80;

  // ****************************************************************
  // queues and event codes
  // ****************************************************************
  localparam int NUM_QUEUES = 8;
  localparam int CAUSE_W    = 8;

  typedef enum logic [2:0] {
    Q_INGRESS_REQUEST,
    Q_CORE_SNOOP,
    Q_SNOOP_RESPONSE_REJECT,
    Q_SNOOP_RESPONSE_RETRY,
    Q_IO_REQUEST,
    Q_REMOTE_REQUEST,
    Q_WRITEBACK,
    Q_OTHER_RETRY
  } queue_e;

  localparam logic [7:0] EV_OCCUPANCY      = 8'h11;
  localparam logic [7:0] EV_IRQ_STAGE1     = 8'h18;
  localparam logic [7:0] EV_IRQ_STAGE2     = 8'h19;
  localparam logic [7:0] EV_PRQ_STAGE1     = 8'h20;
  localparam logic [7:0] EV_PRQ_STAGE2     = 8'h21;
  localparam logic [7:0] EV_IPQ_STAGE1     = 8'h22;
  localparam logic [7:0] EV_IPQ_STAGE2     = 8'h23;
  localparam logic [7:0] EV_SRQ_REJ_STAGE1 = 8'h24;
  localparam logic [7:0] EV_SRQ_REJ_STAGE2 = 8'h25;
  localparam logic [7:0] EV_RRQ_STAGE1     = 8'h26;
  localparam logic [7:0] EV_RRQ_STAGE2     = 8'h27;
  localparam logic [7:0] EV_WBQ_STAGE1     = 8'h28;
  localparam logic [7:0] EV_WBQ_STAGE2     = 8'h29;
  localparam logic [7:0] EV_SRQ_RTY_STAGE1 = 8'h2C;
  localparam logic [7:0] EV_SRQ_RTY_STAGE2 = 8'h2D;
  localparam logic [7:0] EV_OTHER_STAGE1   = 8'h2E;
  localparam logic [7:0] EV_OTHER_STAGE2   = 8'h2F;

  typedef struct packed {
    logic   valid;
    logic   occupancy;
    logic   second;
    queue_e queue;
  } event_sel_s;

  function automatic event_sel_s decode_event(input logic [7:0] code);
    event_sel_s s;
    s = '{valid: 1'b1, occupancy: 1'b0, second: 1'b0, queue: Q_INGRESS_REQUEST};
    case (code)
      EV_OCCUPANCY:      s.occupancy = 1'b1;
      EV_IRQ_STAGE1:     s.queue = Q_INGRESS_REQUEST;
      EV_IRQ_STAGE2:     begin s.queue = Q_INGRESS_REQUEST; s.second = 1'b1; end
      EV_PRQ_STAGE1:     s.queue = Q_IO_REQUEST;
      EV_PRQ_STAGE2:     begin s.queue = Q_IO_REQUEST; s.second = 1'b1; end
      EV_IPQ_STAGE1:     s.queue = Q_CORE_SNOOP;
      EV_IPQ_STAGE2:     begin s.queue = Q_CORE_SNOOP; s.second = 1'b1; end
      EV_SRQ_REJ_STAGE1: s.queue = Q_SNOOP_RESPONSE_REJECT;
      EV_SRQ_REJ_STAGE2: begin s.queue = Q_SNOOP_RESPONSE_REJECT; s.second = 1'b1; end
      EV_RRQ_STAGE1:     s.queue = Q_REMOTE_REQUEST;
      EV_RRQ_STAGE2:     begin s.queue = Q_REMOTE_REQUEST; s.second = 1'b1; end
      EV_WBQ_STAGE1:     s.queue = Q_WRITEBACK;
      EV_WBQ_STAGE2:     begin s.queue = Q_WRITEBACK; s.second = 1'b1; end
      EV_SRQ_RTY_STAGE1: s.queue = Q_SNOOP_RESPONSE_RETRY;
      EV_SRQ_RTY_STAGE2: begin s.queue = Q_SNOOP_RESPONSE_RETRY; s.second = 1'b1; end
      EV_OTHER_STAGE1:   s.queue = Q_OTHER_RETRY;
      EV_OTHER_STAGE2:   begin s.queue = Q_OTHER_RETRY; s.second = 1'b1; end
      default:           s.valid = 1'b0;
    endcase
    return s;
  endfunction

endpackage

// ### verilog/ingress_reject_retry_event_select.sv
// ingress reject/retry/occupancy event selection with apb-reached control and count
// Function
// - mask bit 0 first stage: no address-ring request credit
// - mask bit 1 first stage: no address-ring response credit
// - mask bit 2 first stage: no data-ring response credit
// - mask bit 3 first stage: no data-ring writeback credit
// - mask bit 4 first stage: no data-ring bypass credit
// - mask bit 5 first stage: no data-ring standard credit
// - mask bit 6 first stage: non-link request cannot inject on acknowledge ring
// - mask bit 7 first stage: non-link request cannot inject on invalidate ring
// - second stage bit 0: any first-stage condition of same queue
// - second stage bit 3: request made no snoop filter victim
// - second stage bit 5: cache or filter way conflict
// - second stage bit 7: address matches rejected outstanding request
// - snoop-response queue events count retries of responses to existing requests
// - occupancy adds valid entries of core-snoop (bit 2), remote-request (bit 6) and writeback (bit 7) queues selected in the mask every cycle
// - other-retry counts re-inserts into retry queue, mask gives next cause
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ingress_reject_retry_event_select #(
  parameter int CNT_W = 48,
  parameter int OCC_W = 6
) (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic [11:0]                            paddr,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [31:0]                            pwdata,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic [ingress_event_pkg::NUM_QUEUES*8-1:0] first_stage_cause,
  input  wire logic [ingress_event_pkg::NUM_QUEUES*8-1:0] second_stage_cause,
  input  wire logic [OCC_W-1:0]                       core_snoop_queue_entries,
  input  wire logic [OCC_W-1:0]                       remote_request_queue_entries,
  input  wire logic [OCC_W-1:0]                       writeback_queue_entries,
  output logic                                        counting
);

  localparam int INC_W = OCC_W + 2;

  if (CNT_W <= 32 || CNT_W > 64) begin : g_cnt_w_check
    $error("CNT_W must lie in 33..64");
  end
  if (OCC_W < 1 || OCC_W > 16) begin : g_occ_w_check
    $error("OCC_W must lie in 1..16");
  end

  // ****************************************************************
  // control state
  // ****************************************************************
  logic [7:0]       event_code;
  logic [7:0]       unit_mask;
  logic             enable;
  logic             clear_pulse;
  logic [7:0]       next_event_code;
  logic [7:0]       next_unit_mask;
  logic             next_enable;
  logic             next_clear_pulse;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic [CNT_W-1:0] count_value;
  logic             wr_take;
  logic             known_addr;

  ingress_event_pkg::event_sel_s sel;

  assign sel = ingress_event_pkg::decode_event(event_code);

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == ingress_event_pkg::CTRL_OFFSET) || (a == ingress_event_pkg::COUNT_LO_OFFSET) ||
           (a == ingress_event_pkg::COUNT_HI_OFFSET) || (a == ingress_event_pkg::STATUS_OFFSET);
  endfunction

  // ****************************************************************
  // apb slave: answer registered in setup, taken in access
  // ****************************************************************
  always_comb begin
    known_addr       = is_mapped(paddr);
    wr_take          = psel && penable && pready && pwrite && known_addr;
    next_event_code  = event_code;
    next_unit_mask   = unit_mask;
    next_enable      = enable;
    next_clear_pulse = 1'b0;
    next_pready      = psel && !penable && !pready;
    next_pslverr     = psel && !penable && !pready && !known_addr;
    next_prdata      = '0;
    if (psel && !penable && !pready && !pwrite) begin
      unique case (paddr)
        ingress_event_pkg::CTRL_OFFSET: begin
          next_prdata[ingress_event_pkg::CTRL_CODE_LSB +: 8] = event_code;
          next_prdata[ingress_event_pkg::CTRL_MASK_LSB +: 8] = unit_mask;
          next_prdata[ingress_event_pkg::CTRL_EN_BIT]        = enable;
        end
        ingress_event_pkg::COUNT_LO_OFFSET: next_prdata = count_value[31:0];
        ingress_event_pkg::COUNT_HI_OFFSET: next_prdata = 32'(count_value[CNT_W-1:32]);
        ingress_event_pkg::STATUS_OFFSET: begin
          next_prdata[ingress_event_pkg::STATUS_VALID_BIT]  = sel.valid;
          next_prdata[ingress_event_pkg::STATUS_ACTIVE_BIT] = counting;
        end
        default: next_prdata = '0;
      endcase
    end
    if (wr_take && paddr == ingress_event_pkg::CTRL_OFFSET) begin
      // code and mask held once enabled; only a write that disables may change them
      if (!enable || !pwdata[ingress_event_pkg::CTRL_EN_BIT]) begin
        next_event_code = pwdata[ingress_event_pkg::CTRL_CODE_LSB +: 8];
        next_unit_mask  = pwdata[ingress_event_pkg::CTRL_MASK_LSB +: 8];
      end
      next_enable      = pwdata[ingress_event_pkg::CTRL_EN_BIT];
      next_clear_pulse = pwdata[ingress_event_pkg::CTRL_CLR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_code  <= ingress_event_pkg::CTRL_CODE_RESET;
      unit_mask   <= ingress_event_pkg::CTRL_MASK_RESET;
      enable      <= 1'b0;
      clear_pulse <= 1'b0;
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      event_code  <= next_event_code;
      unit_mask   <= next_unit_mask;
      enable      <= next_enable;
      clear_pulse <= next_clear_pulse;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
    end
  end

  // ****************************************************************
  // condition decode
  // ****************************************************************
  logic [7:0]       s1;
  logic [7:0]       s2;
  logic             first_hit;
  logic             second_hit;
  logic [INC_W-1:0] occ_sum;
  logic [INC_W-1:0] next_inc;
  logic [INC_W-1:0] inc;
  logic             next_counting;

  always_comb begin
    // each queue, snoop-response and other-retry included, takes its own byte of the cause vectors
    s1 = first_stage_cause[sel.queue*8 +: 8];
    s2 = second_stage_cause[sel.queue*8 +: 8];
    first_hit =
      (unit_mask[ingress_event_pkg::ADDR_RING_REQ_CREDIT_MISS] &
       s1[ingress_event_pkg::ADDR_RING_REQ_CREDIT_MISS]) |
      (unit_mask[ingress_event_pkg::ADDR_RING_RSP_CREDIT_MISS] &
       s1[ingress_event_pkg::ADDR_RING_RSP_CREDIT_MISS]) |
      (unit_mask[ingress_event_pkg::DATA_RING_RSP_CREDIT_MISS] &
       s1[ingress_event_pkg::DATA_RING_RSP_CREDIT_MISS]) |
      (unit_mask[ingress_event_pkg::DATA_RING_WRITEBACK_CREDIT_MISS] &
       s1[ingress_event_pkg::DATA_RING_WRITEBACK_CREDIT_MISS]) |
      (unit_mask[ingress_event_pkg::DATA_RING_BYPASS_CREDIT_MISS] &
       s1[ingress_event_pkg::DATA_RING_BYPASS_CREDIT_MISS]) |
      (unit_mask[ingress_event_pkg::DATA_RING_STANDARD_CREDIT_MISS] &
       s1[ingress_event_pkg::DATA_RING_STANDARD_CREDIT_MISS]) |
      (unit_mask[ingress_event_pkg::ACK_RING_INJECT_FAIL] &
       s1[ingress_event_pkg::ACK_RING_INJECT_FAIL]) |
      (unit_mask[ingress_event_pkg::INVAL_RING_INJECT_FAIL] &
       s1[ingress_event_pkg::INVAL_RING_INJECT_FAIL]);
    // bit 0 is the OR of every first-stage cause, whatever the cause input shows there
    s2[ingress_event_pkg::FIRST_STAGE_ANY] = |s1;
    second_hit =
      (unit_mask[ingress_event_pkg::FIRST_STAGE_ANY] & s2[ingress_event_pkg::FIRST_STAGE_ANY]) |
      (unit_mask[ingress_event_pkg::NO_FILTER_VICTIM] & s2[ingress_event_pkg::NO_FILTER_VICTIM]) |
      (unit_mask[ingress_event_pkg::WAY_CONFLICT] & s2[ingress_event_pkg::WAY_CONFLICT]) |
      (unit_mask[ingress_event_pkg::ADDRESS_MATCH_REJECT] &
       s2[ingress_event_pkg::ADDRESS_MATCH_REJECT]) |
      (|(unit_mask & s2 & 8'h56));
    occ_sum = '0;
    if ((unit_mask & ingress_event_pkg::OCC_CORE_SNOOP_MASK) != 8'h00) begin
      occ_sum = occ_sum + INC_W'(core_snoop_queue_entries);
    end
    if ((unit_mask & ingress_event_pkg::OCC_REMOTE_REQUEST_MASK) != 8'h00) begin
      occ_sum = occ_sum + INC_W'(remote_request_queue_entries);
    end
    if ((unit_mask & ingress_event_pkg::OCC_WRITEBACK_MASK) != 8'h00) begin
      occ_sum = occ_sum + INC_W'(writeback_queue_entries);
    end
    next_counting = enable && sel.valid;
    next_inc = '0;
    if (next_counting) begin
      if (sel.occupancy) begin
        next_inc = occ_sum;
      end else if (sel.second) begin
        next_inc = INC_W'(second_hit);
      end else begin
        next_inc = INC_W'(first_hit);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc      <= '0;
      counting <= 1'b0;
    end else begin
      inc      <= next_inc;
      counting <= next_counting;
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  event_accumulator #(
    .CNT_W (CNT_W),
    .INC_W (INC_W)
  ) u_acc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (clear_pulse),
    .inc     (inc),
    .value   (count_value)
  );

endmodule // ingress_reject_retry_event_select

`default_nettype wire
